// ===== src/mdg_top.sv
// MD5 digest engine with AXI4-Lite register slave, input controller and job queue
// Function
// - Hash any message of one bit or more to 128-bit MD5
// - Two caches: fill one, process other
// - Compress a block only once complete
// - Fill free cache; queue job after sixteen words
// - Switch cache when full; wait until processor releases it
// - Append MD5 padding on end marker
// - Insert length; add block if needed
// - One block per 68 clocks
// - Compression takes 65 clocks per block: 64 steps and the add
// - Start wins; resets input and chaining
// - Take word on valid; signal its acceptance
// - Processor starts when idle and job queue nonempty
// - Drive digest and ready flag after last
// - One asynchronous reset initialises everything
// - Single clock domain, 130 MHz target
// - Core no interrupt; wrapper has one
// - Data write latches word with control markers
`timescale 1ns/100ps
`include "mdg_map.svh"
module mdg_top (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // AXI4-Lite write address
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [7:0] S_AXI_AWADDR,
    // AXI4-Lite write data
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    // AXI4-Lite write response
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    output logic [1:0] S_AXI_BRESP,
    // AXI4-Lite read address
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    // AXI4-Lite read data
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    // Event outputs
    output logic WRAPPER_INTERRUPT_OUT,
    output logic DIGEST_RDY
);
    typedef struct packed {
        logic aw_free;
        logic w_free;
        logic ar_free;
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [6:0] ctrl;
        logic [1:0] int_en;
        logic [31:0] data_word;
        logic irq;
        logic in_pend;
        logic [31:0] in_word;
        logic in_start;
        logic in_end;
        logic [4:0] final_bit_index;
        mdg_pkg::mdg_in_e in_st;
        logic sel;
        logic [3:0] idx;
        logic pad_pend;
        logic in_len;
        logic [63:0] len;
        logic [1:0] busy;
        logic [1:0] q_cnt;
        logic [1:0] q_buf;
        logic [1:0] q_last;
        logic p_busy;
        logic p_buf;
        logic p_last;
        logic p_start;
        logic p_init;
    } mdg_top_s;

    mdg_top_s r_reg;
    mdg_top_s r_next;
    logic mem_we;
    logic [4:0] mem_waddr;
    logic [31:0] mem_wdata;
    logic [3:0] rd_addr;
    logic [31:0] m_word;
    logic round_done;
    logic round_rdy;
    logic [127:0] digest;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Cache and round processor

    mdg_cache u_cache (
        .clk(CLK),
        .nrst(NRST),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr({r_reg.p_buf, rd_addr}),
        .rdata(m_word)
    );

    mdg_round u_round (
        .clk(CLK),
        .nrst(NRST),
        .start(r_reg.p_start),
        .last(r_reg.p_last),
        .init(r_reg.p_init),
        .done(round_done),
        .rd_addr(rd_addr),
        .m_word(m_word),
        .digest(digest),
        .rdy(round_rdy)
    );

    ////////////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        mdg_pkg::mdg_reg_e wsel;
        mdg_pkg::mdg_reg_e rsel;
        logic word_rdy;
        logic take;
        logic pad;
        logic last_blk;
        logic [5:0] nbits;
        logic [31:0] stream;
        logic [31:0] word;
        wsel = mdg_pkg::decode(r_reg.aw_addr);
        rsel = mdg_pkg::decode(S_AXI_ARADDR);
        word_rdy = !r_reg.in_pend && r_reg.in_st == mdg_pkg::IN_DATA && !r_reg.busy[r_reg.sel];
        take = 1'b0;
        pad = 1'b0;
        last_blk = 1'b0;
        nbits = `MDG_FULL_BITS;
        stream = '0;
        word = '0;
        mem_we = 1'b0;
        mem_waddr = '0;
        mem_wdata = '0;
        r_next = r_reg;
        r_next.p_start = 1'b0;
        r_next.p_init = 1'b0;

        // Address and data are taken in either order and held until both are in
        if (S_AXI_AWVALID && r_reg.aw_free) begin
            r_next.aw_free = 1'b0;
            r_next.aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && r_reg.w_free) begin
            r_next.w_free = 1'b0;
            r_next.w_data = S_AXI_WDATA;
            r_next.w_strb = S_AXI_WSTRB;
        end
        if (S_AXI_BREADY && r_reg.bvalid) begin
            r_next.bvalid = 1'b0;
        end
        // A data write waits while the previous word is still pending; the late
        // response is the back-pressure seen by software
        if (!r_reg.aw_free && !r_reg.w_free && !r_reg.bvalid
            && !(wsel == mdg_pkg::RG_DATA && r_reg.in_pend)) begin
            r_next.aw_free = 1'b1;
            r_next.w_free = 1'b1;
            r_next.bvalid = 1'b1;
            r_next.bresp = `MDG_RESP_OKAY;
            case (wsel)
                mdg_pkg::RG_INT_EN: begin
                    r_next.int_en = 2'(mdg_pkg::merge({30'h0, r_reg.int_en}, r_reg.w_data,
                        r_reg.w_strb));
                end
                mdg_pkg::RG_CTRL: begin
                    r_next.ctrl = 7'(mdg_pkg::merge({25'h0, r_reg.ctrl}, r_reg.w_data,
                        r_reg.w_strb));
                end
                mdg_pkg::RG_DATA: begin
                    r_next.data_word = mdg_pkg::merge(r_reg.data_word, r_reg.w_data, r_reg.w_strb);
                    r_next.in_pend = 1'b1;
                    r_next.in_word = r_next.data_word;
                    r_next.in_start = r_reg.ctrl[`MDG_CTRL_START];
                    r_next.in_end = r_reg.ctrl[`MDG_CTRL_END];
                    r_next.final_bit_index = r_reg.ctrl[4:0];
                end
                mdg_pkg::RG_STATUS, mdg_pkg::RG_DIGEST: begin
                    r_next.bresp = `MDG_RESP_OKAY;
                end
                default: r_next.bresp = `MDG_RESP_SLVERR;
            endcase
        end

        // Read channel: one read at a time, ARREADY drops until the data is taken
        if (S_AXI_RREADY && r_reg.rvalid) begin
            r_next.rvalid = 1'b0;
            r_next.ar_free = 1'b1;
        end
        if (S_AXI_ARVALID && r_reg.ar_free) begin
            r_next.ar_free = 1'b0;
            r_next.rvalid = 1'b1;
            r_next.rresp = `MDG_RESP_OKAY;
            case (rsel)
                mdg_pkg::RG_STATUS: r_next.rdata = {30'h0, round_rdy, word_rdy};
                mdg_pkg::RG_INT_EN: r_next.rdata = {30'h0, r_reg.int_en};
                mdg_pkg::RG_CTRL: r_next.rdata = {25'h0, r_reg.ctrl};
                mdg_pkg::RG_DATA: r_next.rdata = r_reg.data_word;
                mdg_pkg::RG_DIGEST: begin
                    case (S_AXI_ARADDR[3:2])
                        2'h0: r_next.rdata = digest[127:96];
                        2'h1: r_next.rdata = digest[95:64];
                        2'h2: r_next.rdata = digest[63:32];
                        default: r_next.rdata = digest[31:0];
                    endcase
                end
                default: begin
                    r_next.rdata = `MDG_UNMAPPED;
                    r_next.rresp = `MDG_RESP_SLVERR;
                end
            endcase
        end

        // Interrupt is the enabled status, level only
        r_next.irq = |(r_reg.int_en & {round_rdy, word_rdy});

        // Job queue: a finished block frees its cache, the next job starts after
        if (round_done) begin
            r_next.busy[r_reg.p_buf] = 1'b0;
            r_next.p_busy = 1'b0;
        end
        if (!r_reg.p_busy && r_reg.q_cnt != 2'h0) begin
            r_next.p_busy = 1'b1;
            r_next.p_buf = r_reg.q_buf[0];
            r_next.p_last = r_reg.q_last[0];
            r_next.p_start = 1'b1;
            r_next.q_buf = {1'b0, r_reg.q_buf[1]};
            r_next.q_last = {1'b0, r_reg.q_last[1]};
            r_next.q_cnt = r_reg.q_cnt - 2'h1;
        end

        // A start word aborts whatever was in flight, even alongside an end marker
        if (r_reg.in_pend && r_reg.in_start) begin
            r_next.in_start = 1'b0;
            r_next.in_st = mdg_pkg::IN_DATA;
            r_next.sel = 1'b0;
            r_next.idx = '0;
            r_next.len = '0;
            r_next.pad_pend = 1'b0;
            r_next.in_len = 1'b0;
            r_next.busy = '0;
            r_next.q_cnt = '0;
            r_next.p_busy = 1'b0;
            r_next.p_start = 1'b0;
            r_next.p_init = 1'b1;
        end

        // Input controller, always into the cache the processor does not own
        take = r_reg.in_pend && r_next.in_st == mdg_pkg::IN_DATA
            && !r_next.busy[r_next.sel];
        pad = !take && r_next.in_st == mdg_pkg::IN_PAD && !r_next.busy[r_next.sel];
        if (take) begin
            r_next.in_pend = 1'b0;
            stream = r_reg.in_word;
            if (r_reg.in_end) begin
                // Word is a bit stream from bit 31 down; the index is only read here
                nbits = {1'b0, r_reg.final_bit_index} + 6'h01;
                stream = (r_reg.in_word & ~(32'hFFFFFFFF >> nbits))
                    | (`MDG_PAD_WORD >> nbits);
                r_next.pad_pend = nbits[5];
                r_next.in_st = mdg_pkg::IN_PAD;
            end
            r_next.len = r_next.len + {58'h0, nbits};
            word = mdg_pkg::bswap(stream);
        end else if (pad) begin
            if (r_next.pad_pend) begin
                word = mdg_pkg::bswap(`MDG_PAD_WORD);
            end else if (r_next.idx == `MDG_LEN_IDX) begin
                word = r_next.len[31:0];
                r_next.in_len = 1'b1;
            end else if (r_next.idx == `MDG_LAST_IDX && r_next.in_len) begin
                word = r_next.len[63:32];
                last_blk = 1'b1;
                r_next.in_len = 1'b0;
                r_next.in_st = mdg_pkg::IN_DATA;
            end
            r_next.pad_pend = 1'b0;
        end
        if (take || pad) begin
            mem_we = 1'b1;
            mem_waddr = {r_next.sel, r_next.idx};
            mem_wdata = word;
            // Queue only full blocks; a tail is padded in its block, plus an extra block when the length does not fit
            if (r_next.idx == `MDG_LAST_IDX) begin
                r_next.q_buf[r_next.q_cnt[0]] = r_next.sel;
                r_next.q_last[r_next.q_cnt[0]] = last_blk;
                r_next.q_cnt = r_next.q_cnt + 2'h1;
                r_next.busy[r_next.sel] = 1'b1;
                r_next.sel = !r_next.sel;
                r_next.idx = '0;
            end else begin
                r_next.idx = r_next.idx + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // State register, single clock and single asynchronous reset

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            r_reg <= '0;
            r_reg.aw_free <= 1'b1;
            r_reg.w_free <= 1'b1;
            r_reg.ar_free <= 1'b1;
            r_reg.ctrl <= `MDG_CTRL_RST;
            r_reg.int_en <= `MDG_INT_EN_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign S_AXI_AWREADY = r_reg.aw_free;
    assign S_AXI_WREADY = r_reg.w_free;
    assign S_AXI_BVALID = r_reg.bvalid;
    assign S_AXI_BRESP = r_reg.bresp;
    assign S_AXI_ARREADY = r_reg.ar_free;
    assign S_AXI_RVALID = r_reg.rvalid;
    assign S_AXI_RDATA = r_reg.rdata;
    assign S_AXI_RRESP = r_reg.rresp;
    assign WRAPPER_INTERRUPT_OUT = r_reg.irq;
    assign DIGEST_RDY = round_rdy;
endmodule

// ===== src/mdg_map.svh
// Register offsets, field positions, reset values and constants of the MD5 digest engine
`ifndef MDG_MAP_SVH
`define MDG_MAP_SVH
`define MDG_OFF_STATUS 8'h00
`define MDG_OFF_INT_EN 8'h04
`define MDG_OFF_CTRL 8'h08
`define MDG_OFF_DATA 8'h0C
`define MDG_OFF_DIGEST0 8'h10
`define MDG_OFF_DIGEST1 8'h14
`define MDG_OFF_DIGEST2 8'h18
`define MDG_OFF_DIGEST3 8'h1C
`define MDG_ST_WORD_RDY 0
`define MDG_ST_DIGEST_RDY 1
`define MDG_CTRL_START 6
`define MDG_CTRL_END 5
`define MDG_CTRL_RST 7'h00
`define MDG_INT_EN_RST 2'h0
`define MDG_RESP_OKAY 2'h0
`define MDG_RESP_SLVERR 2'h2
`define MDG_UNMAPPED 32'hFFFFFFFF
`define MDG_INIT_A 32'h67452301
`define MDG_INIT_B 32'hEFCDAB89
`define MDG_INIT_C 32'h98BADCFE
`define MDG_INIT_D 32'h10325476
`define MDG_PAD_WORD 32'h80000000
`define MDG_LEN_IDX 4'hE
`define MDG_LAST_IDX 4'hF
`define MDG_ROUND_LAST 6'h3F
`define MDG_FULL_BITS 6'h20
`endif

// ===== src/mdg_pkg.sv
// Types and shared helper functions of the MD5 digest engine
`include "mdg_map.svh"
package mdg_pkg;
    typedef enum logic [2:0] {RG_STATUS, RG_INT_EN, RG_CTRL, RG_DATA, RG_DIGEST, RG_NONE} mdg_reg_e;
    typedef enum logic {IN_DATA, IN_PAD} mdg_in_e;
    typedef enum logic [1:0] {RN_IDLE, RN_ROUND, RN_ADD} mdg_rnd_e;

    function automatic mdg_reg_e decode(input logic [7:0] addr);
        case (addr)
            `MDG_OFF_STATUS: decode = RG_STATUS;
            `MDG_OFF_INT_EN: decode = RG_INT_EN;
            `MDG_OFF_CTRL: decode = RG_CTRL;
            `MDG_OFF_DATA: decode = RG_DATA;
            `MDG_OFF_DIGEST0, `MDG_OFF_DIGEST1, `MDG_OFF_DIGEST2, `MDG_OFF_DIGEST3: begin
                decode = RG_DIGEST;
            end
            default: decode = RG_NONE;
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            merge[8*i +: 8] = strb[i] ? wd[8*i +: 8] : old[8*i +: 8];
        end
    endfunction

    function automatic logic [31:0] bswap(input logic [31:0] x);
        bswap = {x[7:0], x[15:8], x[23:16], x[31:24]};
    endfunction
endpackage

// ===== src/mdg_cache.sv
// Two 16-word input caches in one memory, registered read port
`timescale 1ns/100ps
module mdg_cache (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Write port, address is {cache, word}
    input wire logic we,
    input wire logic [4:0] waddr,
    input wire logic [31:0] wdata,
    // Read port
    input wire logic [4:0] raddr,
    output logic [31:0] rdata
);
    typedef struct packed {
        logic [31:0][31:0] mem;
        logic [31:0] rdata;
    } mdg_cache_s;

    mdg_cache_s r_reg;
    mdg_cache_s r_next;

    always_comb begin
        r_next = r_reg;
        r_next.rdata = r_reg.mem[raddr];
        if (we) begin
            r_next.mem[waddr] = wdata;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign rdata = r_reg.rdata;
endmodule

// ===== src/mdg_round.sv
// MD5 round processor: one step per clock, then the chaining add
`timescale 1ns/100ps
`include "mdg_map.svh"
module mdg_round (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Job control
    input wire logic start,
    input wire logic last,
    input wire logic init,
    output logic done,
    // Cache read port
    output logic [3:0] rd_addr,
    input wire logic [31:0] m_word,
    // Result
    output logic [127:0] digest,
    output logic rdy
);
    localparam logic [3:0][31:0] INIT_H = {`MDG_INIT_D, `MDG_INIT_C, `MDG_INIT_B, `MDG_INIT_A};
    localparam logic [4:0] S_TAB [16] = '{5'h07, 5'h0C, 5'h11, 5'h16, 5'h05, 5'h09, 5'h0E,
        5'h14, 5'h04, 5'h0B, 5'h10, 5'h17, 5'h06, 5'h0A, 5'h0F, 5'h15};
    localparam logic [31:0] K_TAB [64] = '{
        32'hD76AA478, 32'hE8C7B756, 32'h242070DB, 32'hC1BDCEEE, 32'hF57C0FAF, 32'h4787C62A,
        32'hA8304613, 32'hFD469501, 32'h698098D8, 32'h8B44F7AF, 32'hFFFF5BB1, 32'h895CD7BE,
        32'h6B901122, 32'hFD987193, 32'hA679438E, 32'h49B40821, 32'hF61E2562, 32'hC040B340,
        32'h265E5A51, 32'hE9B6C7AA, 32'hD62F105D, 32'h02441453, 32'hD8A1E681, 32'hE7D3FBC8,
        32'h21E1CDE6, 32'hC33707D6, 32'hF4D50D87, 32'h455A14ED, 32'hA9E3E905, 32'hFCEFA3F8,
        32'h676F02D9, 32'h8D2A4C8A, 32'hFFFA3942, 32'h8771F681, 32'h6D9D6122, 32'hFDE5380C,
        32'hA4BEEA44, 32'h4BDECFA9, 32'hF6BB4B60, 32'hBEBFBC70, 32'h289B7EC6, 32'hEAA127FA,
        32'hD4EF3085, 32'h04881D05, 32'hD9D4D039, 32'hE6DB99E5, 32'h1FA27CF8, 32'hC4AC5665,
        32'hF4292244, 32'h432AFF97, 32'hAB9423A7, 32'hFC93A039, 32'h655B59C3, 32'h8F0CCC92,
        32'hFFEFF47D, 32'h85845DD1, 32'h6FA87E4F, 32'hFE2CE6E0, 32'hA3014314, 32'h4E0811A1,
        32'hF7537E82, 32'hBD3AF235, 32'h2AD7D2BB, 32'hEB86D391};

    typedef struct packed {
        mdg_pkg::mdg_rnd_e st;
        logic [5:0] cnt;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] c;
        logic [31:0] d;
        logic [3:0][31:0] h;
        logic last;
        logic done;
        logic rdy;
        logic [127:0] digest;
    } mdg_rnd_s;

    mdg_rnd_s r_reg;
    mdg_rnd_s r_next;

    function automatic logic [3:0] word_sel(input logic [5:0] i);
        case (i[5:4])
            2'h0: word_sel = i[3:0];
            2'h1: word_sel = 4'h5 * i[3:0] + 4'h1;
            2'h2: word_sel = 4'h3 * i[3:0] + 4'h5;
            default: word_sel = 4'h7 * i[3:0];
        endcase
    endfunction

    function automatic logic [31:0] mix(input logic [1:0] q, input logic [31:0] b,
                                        input logic [31:0] c, input logic [31:0] d);
        case (q)
            2'h0: mix = (b & c) | (~b & d);
            2'h1: mix = (d & b) | (~d & c);
            2'h2: mix = b ^ c ^ d;
            default: mix = c ^ (b | ~d);
        endcase
    endfunction

    function automatic logic [31:0] rotl(input logic [31:0] x, input logic [4:0] s);
        logic [63:0] t;
        t = {x, x} << s;
        rotl = t[63:32];
    endfunction

    always_comb begin
        logic [31:0] sum;
        sum = r_reg.a + mix(r_reg.cnt[5:4], r_reg.b, r_reg.c, r_reg.d)
            + K_TAB[r_reg.cnt] + m_word;
        r_next = r_reg;
        r_next.done = 1'b0;
        if (init) begin
            r_next.st = mdg_pkg::RN_IDLE;
            r_next.h = INIT_H;
            r_next.rdy = 1'b0;
        end else begin
            case (r_reg.st)
                mdg_pkg::RN_IDLE: begin
                    if (start) begin
                        r_next.st = mdg_pkg::RN_ROUND;
                        r_next.cnt = '0;
                        r_next.last = last;
                        {r_next.d, r_next.c, r_next.b, r_next.a} = r_reg.h;
                    end
                end
                mdg_pkg::RN_ROUND: begin
                    r_next.a = r_reg.d;
                    r_next.b = r_reg.b + rotl(sum, S_TAB[{r_reg.cnt[5:4], r_reg.cnt[1:0]}]);
                    r_next.c = r_reg.b;
                    r_next.d = r_reg.c;
                    r_next.cnt = r_reg.cnt + 6'h01;
                    if (r_reg.cnt == `MDG_ROUND_LAST) begin
                        r_next.st = mdg_pkg::RN_ADD;
                    end
                end
                mdg_pkg::RN_ADD: begin
                    r_next.h[0] = r_reg.h[0] + r_reg.a;
                    r_next.h[1] = r_reg.h[1] + r_reg.b;
                    r_next.h[2] = r_reg.h[2] + r_reg.c;
                    r_next.h[3] = r_reg.h[3] + r_reg.d;
                    r_next.done = 1'b1;
                    r_next.st = mdg_pkg::RN_IDLE;
                    if (r_reg.last) begin
                        r_next.rdy = 1'b1;
                        r_next.digest = {mdg_pkg::bswap(r_next.h[0]), mdg_pkg::bswap(r_next.h[1]),
                            mdg_pkg::bswap(r_next.h[2]), mdg_pkg::bswap(r_next.h[3])};
                    end
                end
                default: r_next.st = mdg_pkg::RN_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r_reg <= '0;
            r_reg.h <= INIT_H;
        end else begin
            r_reg <= r_next;
        end
    end

    // Address runs one step ahead because the cache read is registered
    assign rd_addr = (r_reg.st == mdg_pkg::RN_ROUND) ? word_sel(r_reg.cnt + 6'h01) : 4'h0;
    assign done = r_reg.done;
    assign digest = r_reg.digest;
    assign rdy = r_reg.rdy;
endmodule

// ===== testbench/mdg_assertions.sv
// Register bus assertions of the MD5 digest engine
`timescale 1ns/100ps
module mdg_checker (
    // Clock and reset
    input wire logic CLK, NRST,
    // Register bus
    input wire logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY,
    input wire logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY,
    input wire logic S_AXI_RVALID, S_AXI_RREADY,
    input wire logic [1:0] S_AXI_BRESP, S_AXI_RRESP,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic [31:0] S_AXI_RDATA
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    property p_bh; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID; endproperty
    a_bh: assert property (p_bh) else $error("write answer dropped");
    property p_rh; S_AXI_RVALID && !S_AXI_RREADY |=> $stable(S_AXI_RDATA); endproperty
    a_rh: assert property (p_rh) else $error("read data moved");
    property p_ar; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY; endproperty
    a_ar: assert property (p_ar) else $error("read answer late");
    property p_rd; S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID && S_AXI_ARREADY; endproperty
    a_rd: assert property (p_rd) else $error("read not closed");
    property p_um; S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR > 8'h1C
        |=> &S_AXI_RDATA && S_AXI_RRESP == 2'h2; endproperty
    a_um: assert property (p_um) else $error("unmapped read");
    property p_wt; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
        |=> !S_AXI_AWREADY && !S_AXI_WREADY; endproperty
    a_wt: assert property (p_wt) else $error("write slot not held");
    property p_br; $rose(S_AXI_BVALID) |-> S_AXI_AWREADY && S_AXI_WREADY; endproperty
    a_br: assert property (p_br) else $error("write slot not freed");
    property p_rb; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
    a_rb: assert property (p_rb) else $error("read overlap");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind mdg_top mdg_checker mdg_checker_i (.*);

// ===== testbench/mdg_host_model.sv
// Register bus master standing in for the message producer
`timescale 1ns/100ps
module mdg_host_model (
    // Clock
    input wire logic CLK,
    // Requests
    output logic S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY,
    output logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR,
    output logic [31:0] S_AXI_WDATA,
    output logic [3:0] S_AXI_WSTRB,
    // Answers
    input wire logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID,
    input wire logic [1:0] S_AXI_BRESP, S_AXI_RRESP,
    input wire logic [31:0] S_AXI_RDATA
);
    initial begin
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h00;
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 48'h000000000000;
        S_AXI_WSTRB = 4'hF;
    end
    // A stalled word holds its channel until the slave takes it
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge CLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
        forever begin
            @(posedge CLK);
            if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
            if (S_AXI_BVALID) break;
        end
        r = S_AXI_BRESP;
        S_AXI_BREADY <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge CLK);
        S_AXI_ARADDR <= a;
        {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
        forever begin
            @(posedge CLK);
            if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
            if (S_AXI_RVALID) break;
        end
        d = S_AXI_RDATA;
        r = S_AXI_RRESP;
        S_AXI_RREADY <= 1'b0;
    endtask
endmodule

// ===== testbench/test_md5_digest_engine.sv
// Self-checking bench of the MD5 digest engine
`timescale 1ns/100ps
module test_md5_digest_engine;
    logic CLK = 1'b0, NRST = 1'b0, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY;
    logic S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
    logic S_AXI_ARREADY, S_AXI_RVALID, WRAPPER_INTERRUPT_OUT, DIGEST_RDY;
    logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR, a;
    logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rdat, r;
    logic [3:0] S_AXI_WSTRB;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, resp;
    int num_errors = 0, total_checks = 0, cycles = 0;
    string s;
    always #2 CLK = ~CLK;
    mdg_top mdg_top_i (.*);
    mdg_host_model mdg_host_model_i (.*);
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wchk(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
        mdg_host_model_i.wr(ad, d, resp);
        chk(resp, er);
    endtask
    task automatic rchk(input logic [7:0] ad, input logic [31:0] e, input logic [1:0] er);
        mdg_host_model_i.rd(ad, rdat, resp);
        chk(rdat, e);
        chk(resp, er);
    endtask
    // Feeds a byte string as words, then waits for and reads the digest
    task automatic hash(input string m, input logic [127:0] e);
        int n, k;
        logic [31:0] w;
        logic [127:0] dg;
        n = m.len();
        for (int i = 0; i < n; i += 4) begin
            w = 32'h00000000;
            for (int j = 0; j < 4 && i + j < n; j++) w[31-8*j -: 8] = m[i+j];
            k = (n - i >= 4) ? 31 : 8 * (n - i) - 1;
            wchk(8'h08, {25'h0, i == 0, i + 4 >= n, (i + 4 >= n) ? 5'(k) : 5'h00}, 2'h0);
            wchk(8'h0C, w, 2'h0);
            for (int c = 0; c < 8 && i == 0 && DIGEST_RDY; c++) @(posedge CLK);
            if (i == 0) chk(DIGEST_RDY, 1'b0);
        end
        for (int c = 0; c < 3000 && DIGEST_RDY !== 1'b1; c++) @(posedge CLK);
        for (int q = 0; q < 4; q++) begin
            mdg_host_model_i.rd(8'h10 + 8'(4 * q), rdat, resp);
            dg[127-32*q -: 32] = rdat;
        end
        chk(dg, e);
    endtask
    task automatic wrap_up();
        if (num_errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Limit covers three messages and the bus traffic several times over
    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            wrap_up();
        end
    end
    initial begin
        void'($urandom(98691));
        repeat (4) @(posedge CLK);
        NRST <= 1'b1;
        @(posedge CLK);
        rchk(8'h00, 32'h00000001, 2'h0);
        rchk(8'h08, 32'h00000000, 2'h0);
        for (int i = 0; i < 4; i++) begin
            r = $urandom;
            a = 8'($urandom_range(8, 63)) << 2;
            wchk(8'h04, r, 2'h0);
            rchk(8'h04, r & 32'h3, 2'h0);
            wchk(a, r, 2'h2);
            rchk(a, 32'hFFFFFFFF, 2'h2);
        end
        wchk(8'h04, 32'h00000002, 2'h0);
        hash("abc", 128'h900150983CD24FB0D6963F7D28E17F72);
        chk(WRAPPER_INTERRUPT_OUT, 1'b1);
        hash("a", 128'h0CC175B9C0F1B6A831C399E269772661);
        s = "";
        repeat (8) s = {s, "1234567890"};
        hash(s, 128'h57EDF4A22BE3C955AC49DA2E2107B67A);
        wchk(8'h04, 32'h00000000, 2'h0);
        rchk(8'h00, 32'h00000003, 2'h0);
        chk(WRAPPER_INTERRUPT_OUT, 1'b0);
        wrap_up();
    end
endmodule
